// File: inc/dsa_cfg.svh
/*
 * Address map constants and field positions for the data space access unit.
 * Assumes inclusion by bare name from inc/ on the include path.
 */
`ifndef DSA_CFG_SVH
`define DSA_CFG_SVH

`define DSA_ADDR_W 16
`define DSA_DATA_W 16
`define DSA_LOWER_TOP 16'h7FFF
`define DSA_EXT_BASE 16'h8000
`define DSA_RAM_BASE 16'h0800
`define DSA_RAM_TOP 16'h27FF
`define DSA_RAM_WORDS 4096
`define DSA_RAM_IDX_W 12
`define DSA_SPECIAL_TOP 16'h07FF
`define DSA_NEAR_TOP 16'h1FFF
`define DSA_NEAR_W 13
`define DSA_REGION_SHIFT 5
`define DSA_REGION_W 6
`define DSA_REGION_CORE 6'h00
`define DSA_REGION_TIMER 6'h08
`define DSA_STEP_BYTE 16'h0001
`define DSA_STEP_WORD 16'h0002

`endif

// File: inc/dsa_pkg.sv
/*
 * Types shared by the data space access unit files.
 * Assumes dsa_cfg.svh is on the include path.
 */
`include "dsa_cfg.svh"

package dsa_pkg;

    // which part of the byte data space an address lands in
    typedef enum logic [1:0] {
        DSA_SPACE_SPECIAL,
        DSA_SPACE_RAM,
        DSA_SPACE_HOLE,
        DSA_SPACE_EXT
    } dsa_space_type;

    // how a register-file write is shaped
    typedef enum logic [1:0] {
        DSA_EXT_NONE,
        DSA_EXT_SIGN,
        DSA_EXT_ZERO
    } dsa_ext_type;

endpackage : dsa_pkg

// File: verilog/dsa_decode.sv
/*
 * Combinational address decoder: classifies a byte address, gives the RAM word index
 * and the special register region number.
 * Assumes a 16-bit byte address from the same clock domain.
 */
`timescale 1ns/1ps
`include "dsa_cfg.svh"

module dsa_decode (
    input wire logic [15:0] i_addr,
    output dsa_pkg::dsa_space_type o_space,
    output logic [`DSA_RAM_IDX_W-1:0] o_ram_index,
    output logic [`DSA_REGION_W-1:0] o_region
);

    logic [15:0] ram_offset;

    // ************************************************************
    // region and index decode
    // ************************************************************
    always_comb begin
        ram_offset = i_addr - `DSA_RAM_BASE;
        o_ram_index = ram_offset[`DSA_RAM_IDX_W:1];
        o_region = i_addr[`DSA_REGION_SHIFT +: `DSA_REGION_W]; // [R17]
        if (i_addr >= `DSA_EXT_BASE) begin
            o_space = dsa_pkg::DSA_SPACE_EXT; // [R03]
        end else if (i_addr <= `DSA_SPECIAL_TOP) begin
            o_space = dsa_pkg::DSA_SPACE_SPECIAL; // [R15]
        end else if (i_addr <= `DSA_RAM_TOP) begin
            o_space = dsa_pkg::DSA_SPACE_RAM; // [R04]
        end else begin
            o_space = dsa_pkg::DSA_SPACE_HOLE; // [R02]
        end
    end

endmodule : dsa_decode

// File: verilog/dsa_lane_mem.sv
/*
 * Data RAM as two byte-wide lanes with shared word index and separate write enables.
 * Assumes single clock, registered read one cycle after the index is presented.
 */
`timescale 1ns/1ps
`include "dsa_cfg.svh"

module dsa_lane_mem #(
    parameter int WORDS = `DSA_RAM_WORDS,
    parameter int IDX_W = `DSA_RAM_IDX_W
) (
    input wire logic i_mclk,
    input wire logic [IDX_W-1:0] i_rd_index,
    output logic [15:0] o_rd_word,
    input wire logic [IDX_W-1:0] i_wr_index,
    input wire logic i_wr_lo,
    input wire logic i_wr_hi,
    input wire logic [15:0] i_wr_word
);

    logic [7:0] lane_lo [WORDS];
    logic [7:0] lane_hi [WORDS];

    // ************************************************************
    // storage; no reset so it maps to plain arrays
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_wr_lo) begin
            lane_lo[i_wr_index] <= i_wr_word[7:0]; // [R08]
        end
        if (i_wr_hi) begin
            lane_hi[i_wr_index] <= i_wr_word[15:8]; // [R08]
        end
        o_rd_word <= {lane_hi[i_rd_index], lane_lo[i_rd_index]}; // [R05]
    end

endmodule : dsa_lane_mem

// File: verilog/dsa_access_unit.sv
/*
 * Data space access unit: read and write ports from separate address generators,
 * decode into special register space, data RAM and extended window space, byte lanes,
 * pointer post-increment scaling, register-file byte merge and extend operations,
 * and the misaligned-access trap pulse.
 * Assumes the execution unit holds a request for one cycle, that special register
 * and extended window data are returned combinationally in the cycle after the
 * request, and that the trap pulse is consumed by exception logic on the same clock.
 */
//
// Overview of operation
// [R01] each 16-bit address names one byte; 64 Kbytes organised as 16-bit words
// [R02] addresses 0000h to 7FFFh decode to on-chip special registers and RAM; here 2800h to 7FFFh is a hole that reads zero
// [R03] addresses 8000h to FFFFh go to the extended window space port
// [R04] 8 Kbytes of data RAM live at byte addresses 0800h to 27FFh
// [R05] low byte sits at the even address, high byte at the next odd one
// [R06] pointer post-increment adds 1 for byte and 2 for word operations
// [R07] byte read fetches the whole word and steers byte by bit 0 to low lane
// [R08] shared word index with separate lane write enables for byte writes
// [R09] word read or write at an odd address is misaligned and traps
// [R10] misaligned read still completes; misaligned write store is suppressed; trap after
// [R11] byte load into a working register changes only its low byte
// [R12] sign-extend widens signed byte to word; zero-extend clears the high byte
// [R13] near field of 13 bits reaches 0000h to 1FFFh directly
// [R14] move instructions reach the whole space with a full 16-bit field
// [R15] 0000h to 07FFh is mostly special registers for core and peripherals
// [R16] unimplemented special register addresses read as zero
// [R17] special register decode is grouped in 32-byte regions per module
// [R18] separate read and write address generators feed the block
// [R19] address error is a one-cycle pulse tied to the misaligned access
//
`timescale 1ns/1ps
`include "dsa_cfg.svh"

module dsa_access_unit #(
    parameter int RAM_WORDS = `DSA_RAM_WORDS,
    parameter logic [63:0] REGION_MAP = 64'hFFFF_FFFF_FFFF_FFFF
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    // read address generator
    input wire logic i_rd_req,
    input wire logic i_rd_byte,
    input wire logic i_rd_near,
    input wire logic [15:0] i_rd_addr,
    // write address generator
    input wire logic i_wr_req,
    input wire logic i_wr_byte,
    input wire logic i_wr_near,
    input wire logic [15:0] i_wr_addr,
    input wire logic [15:0] i_wr_data,
    // pointer post-increment request
    input wire logic i_ptr_inc,
    input wire logic i_ptr_byte,
    input wire logic [15:0] i_ptr_value,
    // working register load shaping
    input wire logic i_reg_load,
    input wire logic [15:0] i_reg_old,
    input wire logic [1:0] i_reg_ext,
    // special register and extended window return data
    input wire logic [15:0] i_special_rdata,
    input wire logic [15:0] i_ext_rdata,
    // results
    output logic o_rd_valid,
    output logic [15:0] o_rd_data,
    output logic o_special_rd,
    output logic o_special_wr,
    output logic o_ext_rd,
    output logic o_ext_wr,
    output logic [15:0] o_port_addr,
    output logic [15:0] o_port_wdata,
    output logic [1:0] o_port_lanes,
    output logic [15:0] o_ptr_next,
    output logic [15:0] o_reg_new,
    output logic o_addr_error
);

    typedef struct packed {
        logic rd_valid;
        logic [1:0] rd_src;
        logic rd_byte;
        logic rd_odd;
        logic rd_unimpl;
        logic [15:0] rd_data;
        logic special_rd;
        logic special_wr;
        logic ext_rd;
        logic ext_wr;
        logic [15:0] port_addr;
        logic [15:0] port_wdata;
        logic [1:0] port_lanes;
        logic [15:0] ptr_next;
        logic [15:0] reg_new;
        logic addr_error;
    } dsa_state_type;

    dsa_state_type state;
    dsa_state_type next_state;

    logic [15:0] rd_eff;
    logic [15:0] wr_eff;
    dsa_pkg::dsa_space_type rd_space;
    dsa_pkg::dsa_space_type wr_space;
    logic [`DSA_RAM_IDX_W-1:0] rd_index;
    logic [`DSA_RAM_IDX_W-1:0] wr_index;
    logic [`DSA_REGION_W-1:0] rd_region;
    logic [`DSA_REGION_W-1:0] wr_region;
    logic [15:0] ram_word;
    logic rd_misaligned;
    logic wr_misaligned;
    logic wr_ram_lo;
    logic wr_ram_hi;
    logic [1:0] wr_lanes;
    logic [15:0] word_in;
    logic [15:0] shaped;

    // ************************************************************
    // helpers
    // ************************************************************

    // near field keeps only 13 bits, so it can never leave 0000h..1FFFh
    function automatic logic [15:0] effective(input logic near, input logic [15:0] a);
        effective = near ? {3'h0, a[`DSA_NEAR_W-1:0]} : a; // [R13] [R14]
    endfunction : effective

    // word access at an odd byte address cannot be served
    function automatic logic misaligned(input logic is_byte, input logic [15:0] a);
        misaligned = !is_byte && a[0]; // [R09]
    endfunction : misaligned

    // byte lanes touched by an access
    function automatic logic [1:0] lanes(input logic is_byte, input logic [15:0] a);
        lanes = is_byte ? (a[0] ? 2'h2 : 2'h1) : 2'h3; // [R05] [R08]
    endfunction : lanes

    // a region with no implemented register reads as zero
    function automatic logic region_live(input logic [`DSA_REGION_W-1:0] r);
        region_live = REGION_MAP[r]; // [R17]
    endfunction : region_live

    // ************************************************************
    // address decode, one per generator
    // ************************************************************
    assign rd_eff = effective(i_rd_near, i_rd_addr); // [R18]
    assign wr_eff = effective(i_wr_near, i_wr_addr); // [R18]

    dsa_decode u_rd_decode (
        .i_addr(rd_eff),
        .o_space(rd_space),
        .o_ram_index(rd_index),
        .o_region(rd_region)
    );

    dsa_decode u_wr_decode (
        .i_addr(wr_eff),
        .o_space(wr_space),
        .o_ram_index(wr_index),
        .o_region(wr_region)
    );

    // ************************************************************
    // write path into RAM lanes
    // ************************************************************
    // misaligned writes are dropped here; the trap still follows
    assign wr_misaligned = misaligned(i_wr_byte, wr_eff);
    assign rd_misaligned = misaligned(i_rd_byte, rd_eff);
    assign wr_lanes = lanes(i_wr_byte, wr_eff);
    assign wr_ram_lo = i_wr_req && !wr_misaligned && wr_space == dsa_pkg::DSA_SPACE_RAM
        && wr_lanes[0]; // [R10]
    assign wr_ram_hi = i_wr_req && !wr_misaligned && wr_space == dsa_pkg::DSA_SPACE_RAM
        && wr_lanes[1]; // [R10]
    // byte data arrives in the low byte; copy it to both lanes
    assign word_in = i_wr_byte ? {i_wr_data[7:0], i_wr_data[7:0]} : i_wr_data;

    dsa_lane_mem #(
        .WORDS(RAM_WORDS),
        .IDX_W(`DSA_RAM_IDX_W)
    ) u_ram (
        .i_mclk(i_mclk),
        .i_rd_index(rd_index),
        .o_rd_word(ram_word),
        .i_wr_index(wr_index),
        .i_wr_lo(wr_ram_lo),
        .i_wr_hi(wr_ram_hi),
        .i_wr_word(word_in)
    );

    // ************************************************************
    // register-file load shaping
    // ************************************************************
    always_comb begin
        unique case (i_reg_ext)
            2'h1: shaped = {{8{i_reg_old[7]}}, i_reg_old[7:0]}; // [R12]
            2'h2: shaped = {8'h00, i_reg_old[7:0]}; // [R12]
            default: shaped = i_reg_old;
        endcase
    end

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        logic [15:0] word_sel;
        word_sel = 16'h0000;
        next_state = state;
        next_state.special_rd = 1'b0;
        next_state.special_wr = 1'b0;
        next_state.ext_rd = 1'b0;
        next_state.ext_wr = 1'b0;
        next_state.addr_error = 1'b0;
        next_state.rd_valid = 1'b0;

        // stage 2: pick the returned word and steer the byte
        unique case (state.rd_src)
            2'h0: word_sel = ram_word;
            2'h1: word_sel = state.rd_unimpl ? 16'h0000 : i_special_rdata; // [R16]
            2'h2: word_sel = i_ext_rdata;
            default: word_sel = 16'h0000; // hole between RAM and window reads zero
        endcase
        if (state.rd_valid) begin
            if (state.rd_byte) begin
                next_state.rd_data = {8'h00, state.rd_odd ? word_sel[15:8] : word_sel[7:0]}; // [R07]
            end else begin
                next_state.rd_data = word_sel;
            end
        end

        // stage 1: read request; a misaligned read still completes
        if (i_rd_req) begin
            next_state.rd_valid = 1'b1; // [R10]
            next_state.rd_byte = i_rd_byte;
            next_state.rd_odd = rd_eff[0]; // [R07]
            next_state.rd_unimpl = !region_live(rd_region);
            unique case (rd_space)
                dsa_pkg::DSA_SPACE_RAM: next_state.rd_src = 2'h0;
                dsa_pkg::DSA_SPACE_SPECIAL: begin
                    next_state.rd_src = 2'h1;
                    next_state.special_rd = region_live(rd_region);
                end
                dsa_pkg::DSA_SPACE_EXT: begin
                    next_state.rd_src = 2'h2;
                    next_state.ext_rd = 1'b1; // [R03]
                end
                dsa_pkg::DSA_SPACE_HOLE: next_state.rd_src = 2'h3;
            endcase
            next_state.port_addr = {rd_eff[15:1], 1'b0}; // [R01]
            next_state.port_lanes = 2'h3;
        end

        // write request takes the side port when no read owns it
        if (i_wr_req && !wr_misaligned) begin
            if (wr_space == dsa_pkg::DSA_SPACE_SPECIAL && region_live(wr_region)) begin
                next_state.special_wr = !i_rd_req || rd_space != dsa_pkg::DSA_SPACE_SPECIAL;
            end
            if (wr_space == dsa_pkg::DSA_SPACE_EXT) begin
                next_state.ext_wr = !i_rd_req || rd_space != dsa_pkg::DSA_SPACE_EXT; // [R03]
            end
            if (!i_rd_req || rd_space == dsa_pkg::DSA_SPACE_RAM) begin
                next_state.port_addr = {wr_eff[15:1], 1'b0};
                next_state.port_lanes = wr_lanes; // [R08]
                next_state.port_wdata = word_in;
            end
        end

        // trap pulse, one cycle, after the access that caused it
        next_state.addr_error = (i_rd_req && rd_misaligned) || (i_wr_req && wr_misaligned); // [R09] [R19]

        // pointer scaling
        if (i_ptr_inc) begin
            next_state.ptr_next = i_ptr_value + (i_ptr_byte ? `DSA_STEP_BYTE : `DSA_STEP_WORD); // [R06]
        end

        // byte load merges into the low byte only
        if (i_reg_load) begin
            if (i_reg_ext != 2'h0) begin
                next_state.reg_new = shaped;
            end else begin
                next_state.reg_new = {i_reg_old[15:8], state.rd_data[7:0]}; // [R11]
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_rd_valid = state.rd_valid;
    assign o_rd_data = state.rd_data;
    assign o_special_rd = state.special_rd;
    assign o_special_wr = state.special_wr;
    assign o_ext_rd = state.ext_rd;
    assign o_ext_wr = state.ext_wr;
    assign o_port_addr = state.port_addr;
    assign o_port_wdata = state.port_wdata;
    assign o_port_lanes = state.port_lanes;
    assign o_ptr_next = state.ptr_next;
    assign o_reg_new = state.reg_new;
    assign o_addr_error = state.addr_error;

endmodule : dsa_access_unit

// File: verif/dsa_side_model.sv
/*
 * far-side model: special register and extended window responders.
 * assumes the unit samples return data in the cycle its read strobe is high.
 */
`timescale 1ns/1ps
module dsa_side_model (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_special_rd,
    input wire logic i_ext_rd,
    input wire logic [15:0] i_port_addr,
    output logic [15:0] o_special_rdata,
    output logic [15:0] o_ext_rdata
);
    // ********************
    // responders
    // ********************
    logic [15:0] churn;
    // idle pattern moves every cycle so stale data cannot pass for a reply
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            churn <= 16'h5A5A;
        end else begin
            churn <= churn + 16'h3C5B;
        end
    end
    // reply only while strobed: a fixed scramble of the word address
    assign o_special_rdata = i_special_rd ? (i_port_addr ^ 16'hC3A5) : churn;
    assign o_ext_rdata = i_ext_rd ? (i_port_addr ^ 16'hC3A5) : ~churn;
endmodule : dsa_side_model

// File: verif/dsa_access_unit_chk.sv
/*
 * port checker for the data space access unit: trap, strobes, lanes, data.
 * assumes the default clocking of one core clock and async high reset.
 */
`timescale 1ns/1ps
module dsa_access_unit_chk #(
    parameter int RAM_WORDS = 4096,
    parameter logic [63:0] REGION_MAP = 64'hFFFF_FFFF_FFFF_FFFF
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_rd_req,
    input wire logic i_rd_byte,
    input wire logic i_rd_near,
    input wire logic [15:0] i_rd_addr,
    input wire logic i_wr_req,
    input wire logic i_wr_byte,
    input wire logic i_wr_near,
    input wire logic [15:0] i_wr_addr,
    input wire logic i_ptr_inc,
    input wire logic i_ptr_byte,
    input wire logic [15:0] i_ptr_value,
    input wire logic i_reg_load,
    input wire logic [15:0] i_reg_old,
    input wire logic [1:0] i_reg_ext,
    input wire logic [15:0] i_ext_rdata,
    input wire logic o_rd_valid,
    input wire logic [15:0] o_rd_data,
    input wire logic o_ext_rd,
    input wire logic o_ext_wr,
    input wire logic o_special_wr,
    input wire logic [15:0] o_port_addr,
    input wire logic [1:0] o_port_lanes,
    input wire logic [15:0] o_ptr_next,
    input wire logic [15:0] o_reg_new,
    input wire logic o_addr_error
);
    // ********************
    // properties
    // ********************
    logic mis_any;
    // either generator asking for a word at an odd address
    assign mis_any = (i_rd_req && !i_rd_byte && i_rd_addr[0])
        || (i_wr_req && !i_wr_byte && i_wr_addr[0]);
    default clocking dc @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    sequence s_ext_wr;
        i_wr_req && !i_rd_req && !i_wr_near && i_wr_addr[15] && (i_wr_byte || !i_wr_addr[0]);
    endsequence
    sequence s_ext_byte_rd;
        i_rd_req && i_rd_byte && !i_rd_near && i_rd_addr[15] ##1 o_ext_rd;
    endsequence
    property p_mis_rd;
        i_rd_req && !i_rd_byte && i_rd_addr[0] |=> o_addr_error && o_rd_valid;
    endproperty
    a_mis_rd: assert property (p_mis_rd) else $error("misaligned read lost");
    property p_mis_wr;
        i_wr_req && !i_wr_byte && i_wr_addr[0] |=> o_addr_error && !o_ext_wr && !o_special_wr;
    endproperty
    a_mis_wr: assert property (p_mis_wr) else $error("misaligned store leaked");
    property p_err_cause;
        o_addr_error |-> $past(mis_any);
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("stray address error");
    property p_ext_wr;
        s_ext_wr |=> o_ext_wr && o_port_addr == {$past(i_wr_addr[15:1]), 1'h0};
    endproperty
    a_ext_wr: assert property (p_ext_wr) else $error("window write missing");
    // the byte is steered by the address two cycles back, data one back
    property p_ext_byte_rd;
        s_ext_byte_rd |=> o_rd_data == {8'h00, $past(i_rd_addr[0], 2)
            ? $past(i_ext_rdata[15:8]) : $past(i_ext_rdata[7:0])};
    endproperty
    a_ext_byte_rd: assert property (p_ext_byte_rd) else $error("byte steer wrong");
    property p_zero_rd;
        i_rd_req && !i_rd_near && (i_rd_addr inside {[16'h2800:16'h7FFF]}
            || (i_rd_addr < 16'h0800 && !REGION_MAP[i_rd_addr[10:5]]))
            |-> ##2 o_rd_data == 16'h0000;
    endproperty
    a_zero_rd: assert property (p_zero_rd) else $error("empty space not zero");
    property p_lane;
        i_wr_req && i_wr_byte && !i_rd_req && !i_wr_near
            && i_wr_addr inside {[16'h0800:16'h27FF]}
            |=> o_port_lanes == ($past(i_wr_addr[0]) ? 2'h2 : 2'h1);
    endproperty
    a_lane: assert property (p_lane) else $error("byte lane wrong");
    property p_ptr;
        i_ptr_inc |=> o_ptr_next == $past(i_ptr_value) + ($past(i_ptr_byte) ? 16'h0001 : 16'h0002);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer step wrong");
    property p_merge;
        i_reg_load && i_reg_ext == 2'h0
            |=> o_reg_new == {$past(i_reg_old[15:8]), $past(o_rd_data[7:0])};
    endproperty
    a_merge: assert property (p_merge) else $error("byte load touched high byte");
endmodule : dsa_access_unit_chk

bind dsa_access_unit dsa_access_unit_chk #(.RAM_WORDS(RAM_WORDS), .REGION_MAP(REGION_MAP)) u_chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_rd_req(i_rd_req), .i_rd_byte(i_rd_byte),
    .i_rd_near(i_rd_near), .i_rd_addr(i_rd_addr), .i_wr_req(i_wr_req),
    .i_wr_byte(i_wr_byte), .i_wr_near(i_wr_near), .i_wr_addr(i_wr_addr),
    .i_ptr_inc(i_ptr_inc), .i_ptr_byte(i_ptr_byte), .i_ptr_value(i_ptr_value),
    .i_reg_load(i_reg_load), .i_reg_old(i_reg_old), .i_reg_ext(i_reg_ext),
    .i_ext_rdata(i_ext_rdata), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_ext_rd(o_ext_rd), .o_ext_wr(o_ext_wr), .o_special_wr(o_special_wr),
    .o_port_addr(o_port_addr), .o_port_lanes(o_port_lanes), .o_ptr_next(o_ptr_next),
    .o_reg_new(o_reg_new), .o_addr_error(o_addr_error));

// File: verif/dsa_access_unit_tb.sv
/*
 * self-checking bench for the data space access unit with a side responder.
 * assumes the checker is bound to the unit; one 125 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module dsa_access_unit_tb;
    typedef struct packed {
        logic we; logic wb; logic [15:0] wa; logic [15:0] wd;
        logic rb; logic n; logic [15:0] ra; logic [15:0] ex;
    } dsa_row_type;
    logic i_mclk, i_rst, i_rd_req, i_rd_byte, i_rd_near, i_wr_req, i_wr_byte, i_wr_near;
    logic i_ptr_inc, i_ptr_byte, i_reg_load;
    logic [1:0] i_reg_ext, o_port_lanes;
    logic [15:0] i_rd_addr, i_wr_addr, i_wr_data, i_ptr_value, i_reg_old;
    logic [15:0] i_special_rdata, i_ext_rdata, o_rd_data, o_port_addr, o_port_wdata;
    logic [15:0] o_ptr_next, o_reg_new;
    logic o_rd_valid, o_special_rd, o_special_wr, o_ext_rd, o_ext_wr, o_addr_error;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [15:0] rx [3] = '{16'hABEF, 16'hFF80, 16'h0080};
    // write, then read back; byte rows probe lanes, near rows drop bits 15:13
    dsa_row_type rows [12] = '{
        '{1'h1, 1'h0, 16'h0800, 16'hA5C3, 1'h0, 1'h0, 16'h0800, 16'hA5C3},
        '{1'h1, 1'h1, 16'h0801, 16'h007E, 1'h0, 1'h0, 16'h0800, 16'h7EC3},
        '{1'h1, 1'h1, 16'h0800, 16'h0011, 1'h1, 1'h0, 16'h0801, 16'h007E},
        '{1'h1, 1'h0, 16'h27FE, 16'h1234, 1'h1, 1'h0, 16'h27FE, 16'h0034},
        '{1'h1, 1'h0, 16'h2800, 16'hFFFF, 1'h0, 1'h0, 16'h2800, 16'h0000},
        '{1'h1, 1'h0, 16'h8004, 16'hBBBB, 1'h0, 1'h0, 16'h8002, 16'h43A7},
        '{1'h0, 1'h0, 16'h0000, 16'h0000, 1'h1, 1'h0, 16'h8003, 16'h0043},
        '{1'h0, 1'h0, 16'h0000, 16'h0000, 1'h0, 1'h0, 16'h0100, 16'hC2A5},
        '{1'h1, 1'h0, 16'hA900, 16'h5555, 1'h0, 1'h1, 16'hA900, 16'h5555},
        '{1'h1, 1'h0, 16'h2000, 16'h0F0F, 1'h0, 1'h0, 16'h2000, 16'h0F0F},
        '{1'h0, 1'h0, 16'h0000, 16'h0000, 1'h0, 1'h1, 16'h8110, 16'hC2B5},
        '{1'h0, 1'h0, 16'h0000, 16'h0000, 1'h0, 1'h0, 16'h0700, 16'h0000}};

    // region at 700h left unimplemented so its reads must come back zero
    dsa_access_unit #(.REGION_MAP(64'hFEFF_FFFF_FFFF_FFFF)) dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_rd_req(i_rd_req), .i_rd_byte(i_rd_byte),
        .i_rd_near(i_rd_near), .i_rd_addr(i_rd_addr), .i_wr_req(i_wr_req),
        .i_wr_byte(i_wr_byte), .i_wr_near(i_wr_near), .i_wr_addr(i_wr_addr),
        .i_wr_data(i_wr_data), .i_ptr_inc(i_ptr_inc), .i_ptr_byte(i_ptr_byte),
        .i_ptr_value(i_ptr_value), .i_reg_load(i_reg_load), .i_reg_old(i_reg_old),
        .i_reg_ext(i_reg_ext), .i_special_rdata(i_special_rdata),
        .i_ext_rdata(i_ext_rdata), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
        .o_special_rd(o_special_rd), .o_special_wr(o_special_wr), .o_ext_rd(o_ext_rd),
        .o_ext_wr(o_ext_wr), .o_port_addr(o_port_addr), .o_port_wdata(o_port_wdata),
        .o_port_lanes(o_port_lanes), .o_ptr_next(o_ptr_next), .o_reg_new(o_reg_new),
        .o_addr_error(o_addr_error));
    dsa_side_model u_side (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_special_rd(o_special_rd), .i_ext_rd(o_ext_rd),
        .i_port_addr(o_port_addr), .o_special_rdata(i_special_rdata),
        .o_ext_rdata(i_ext_rdata));

    // ********************
    // tasks and run
    // ********************
    task automatic conclude();
        $display("tests %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // one-cycle requests; each returns at the edge that takes it
    task automatic wr(input logic b, input logic n, input logic [15:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        {i_wr_req, i_wr_byte, i_wr_near, i_wr_addr, i_wr_data} <= {1'h1, b, n, a, d};
        @(posedge i_mclk);
        i_wr_req <= 1'h0;
    endtask : wr
    task automatic rd(input logic b, input logic n, input logic [15:0] a);
        @(posedge i_mclk);
        {i_rd_req, i_rd_byte, i_rd_near, i_rd_addr} <= {1'h1, b, n, a};
        @(posedge i_mclk);
        i_rd_req <= 1'h0;
    endtask : rd
    initial begin
        i_mclk = 1'h0;
        forever #4 i_mclk = ~i_mclk;
    end
    // cut a hang short well past the expected 92 cycles
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 1000) begin
            n_fail++;
            $display("mismatch at %0t: timeout", $time);
            conclude();
        end
    end
    initial begin
        {i_rst, i_rd_req, i_rd_byte, i_rd_near, i_wr_req, i_wr_byte, i_wr_near} = 7'h40;
        {i_ptr_inc, i_ptr_byte, i_reg_load, i_reg_ext} = 5'h00;
        {i_rd_addr, i_wr_addr, i_wr_data, i_ptr_value, i_reg_old} = 80'h0;
        repeat (20) @(posedge i_mclk);
        #1;
        `CHK({o_rd_valid, o_addr_error, o_ptr_next, o_reg_new, o_rd_data}, 50'h0)
        @(posedge i_mclk);
        i_rst <= 1'h0;
        for (int k = 0; k < 12; k++) begin
            if (rows[k].we) begin
                wr(rows[k].wb, rows[k].n, rows[k].wa, rows[k].wd);
            end
            rd(rows[k].rb, rows[k].n, rows[k].ra);
            #1;
            `CHK(o_rd_valid, 1'h1)
            @(posedge i_mclk);
            #1;
            `CHK(o_rd_data, rows[k].ex)
        end
        // misaligned store is dropped, misaligned fetch still completes
        wr(1'h0, 1'h0, 16'h0804, 16'hBEEF);
        #1;
        `CHK({o_port_addr, o_port_wdata, o_port_lanes}, {16'h0804, 16'hBEEF, 2'h3})
        wr(1'h0, 1'h0, 16'h0805, 16'h0000);
        #1;
        `CHK(o_addr_error, 1'h1)
        rd(1'h0, 1'h0, 16'h0805);
        #1;
        `CHK({o_rd_valid, o_addr_error}, 2'h3)
        rd(1'h0, 1'h0, 16'h0804);
        @(posedge i_mclk);
        #1;
        `CHK(o_rd_data, 16'hBEEF)
        // byte merge, sign extend, zero extend of one register value
        for (int k = 0; k < 3; k++) begin
            @(posedge i_mclk);
            {i_reg_load, i_reg_ext, i_reg_old} <= {1'h1, k[1:0], 16'hAB80};
            @(posedge i_mclk);
            i_reg_load <= 1'h0;
            #1;
            `CHK(o_reg_new, rx[k])
        end
        // byte and word steps across the top of the space
        for (int k = 0; k < 2; k++) begin
            @(posedge i_mclk);
            {i_ptr_inc, i_ptr_byte, i_ptr_value} <= {1'h1, k == 0, 16'hFFFF};
            @(posedge i_mclk);
            i_ptr_inc <= 1'h0;
            #1;
            `CHK(o_ptr_next, (k == 0) ? 16'h0000 : 16'h0001)
        end
        conclude();
    end
endmodule : dsa_access_unit_tb
